// File: rtl/fcs_pkg.sv
package fcs_pkg;

    // clock and operation times
    localparam int unsigned CLK_PERIOD_NS        = 20;
    localparam int unsigned PROG_TIME_US         = 40;
    localparam int unsigned PROTECT_TIME_US      = 40;
    localparam int unsigned SECTOR_ERASE_TIME_MS = 30;
    localparam int unsigned CHIP_ERASE_TIME_MS   = 30;
    localparam int unsigned PROG_CYC         = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned PROTECT_CYC      = PROTECT_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned CHIP_ERASE_CYC   = CHIP_ERASE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W          = 21;

    // unlock addresses and command codes
    localparam logic [11:0] UNLOCK_ADDR_A    = 12'h555;
    localparam logic [11:0] UNLOCK_ADDR_B    = 12'haaa;
    localparam logic [7:0]  CODE_UNLOCK_A    = 8'haa;
    localparam logic [7:0]  CODE_UNLOCK_B    = 8'h55;
    localparam logic [7:0]  CODE_PROGRAM     = 8'ha0;
    localparam logic [7:0]  CODE_ERASE       = 8'h80;
    localparam logic [7:0]  CODE_SECTOR      = 8'h30;
    localparam logic [7:0]  CODE_CHIP        = 8'h10;
    localparam logic [7:0]  CODE_ID_ENTER    = 8'h90;
    localparam logic [7:0]  CODE_ID_EXIT     = 8'hf0;
    localparam logic [7:0]  CODE_PROTECT     = 8'ha5;
    localparam logic [7:0]  CODE_PROTECT_CFM = 8'h00;

    // read values
    localparam logic [7:0]  ERASED_BYTE      = 8'hff;
    localparam logic [7:0]  PROTECT_OFF_VAL  = 8'hff;
    localparam logic [7:0]  PROTECT_ON_VAL   = 8'h00;
    localparam logic [7:0]  BLOCKED_READ_VAL = 8'hff;
    localparam logic [7:0]  UNMAPPED_VAL     = 8'h00;
    localparam logic [7:0]  SIZE_CODE        = 8'h0e;
    localparam int unsigned BUSY_TOGGLE_BIT  = 6;

    // address map
    localparam logic [15:0] PROTECT_ADDR     = 16'hff7f;
    localparam logic [15:0] ID_VENDOR_ADDR   = 16'hf000;
    localparam logic [15:0] ID_MACRO_ADDR    = 16'hf001;
    localparam logic [15:0] ID_SIZE_ADDR     = 16'hf002;
    localparam logic [15:0] ARRAY_BASE       = 16'h1000;
    localparam logic [15:0] ARRAY_LAST_IDX   = 16'hefff;
    localparam logic [15:0] SECTOR_LAST_OFS  = 16'h0fff;
    localparam logic [15:0] BANK0_OFFSET     = 16'h8000;
    localparam int unsigned ARRAY_DEPTH      = 61440;

    // flash control register
    localparam int unsigned CMD_EN_LSB       = 4;
    localparam int unsigned BANK_SEL_BIT     = 3;
    localparam logic [3:0]  CMD_ENABLE       = 4'h3;
    localparam logic [3:0]  CMD_DISABLE      = 4'hc;
    localparam logic [7:0]  CTL_RESET        = 8'hc8;

    typedef enum logic [1:0] {
        FCS_MODE_MCU      = 2'h0,
        FCS_MODE_SERIAL   = 2'h1,
        FCS_MODE_PARALLEL = 2'h2
    } fcs_mode_type;

    typedef enum logic [1:0] {
        FCS_OP_PROGRAM = 2'h0,
        FCS_OP_SECTOR  = 2'h1,
        FCS_OP_CHIP    = 2'h2,
        FCS_OP_PROTECT = 2'h3
    } fcs_op_type;

    typedef enum logic [8:0] {
        FCS_ST_IDLE = 9'h001,
        FCS_ST_U1   = 9'h002,
        FCS_ST_U2   = 9'h004,
        FCS_ST_PROG = 9'h008,
        FCS_ST_E3   = 9'h010,
        FCS_ST_E4   = 9'h020,
        FCS_ST_E5   = 9'h040,
        FCS_ST_RP   = 9'h080,
        FCS_ST_BUSY = 9'h100
    } fcs_state_type;

endpackage : fcs_pkg

// File: rtl/fcs_arr_if.sv
`timescale 1ns/100ps
interface fcs_arr_if;
    logic        we;
    logic [15:0] waddr;
    logic [7:0]  wdata;
    logic [15:0] raddr;
    logic [7:0]  rdata;

    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : fcs_arr_if

// File: rtl/fcs_array.sv
`timescale 1ns/100ps
module fcs_array
    import fcs_pkg::*;
(
    // clock
    input wire logic  clk,
    // array port
    fcs_arr_if.mem    port
);

    logic [7:0] mem_q [ARRAY_DEPTH];

    always_ff @(posedge clk)
    begin
        if (port.we && (32'(port.waddr) < ARRAY_DEPTH))
        begin
            mem_q[port.waddr] <= port.wdata;
        end
    end

    // out-of-range reads answer zero rather than unknown
    always_ff @(posedge clk)
    begin
        if (32'(port.raddr) < ARRAY_DEPTH)
        begin
            port.rdata <= mem_q[port.raddr];
        end
        else
        begin
            port.rdata <= UNMAPPED_VAL;
        end
    end

endmodule : fcs_array

// File: rtl/fcs_timer.sv
`timescale 1ns/100ps
module fcs_timer
    import fcs_pkg::*;
(
    // clock and reset
    input wire logic                clk,
    input wire logic                rst_n,
    // control
    input wire logic                start,
    input wire logic [TIMER_W-1:0]  load,
    // status
    output logic                    expired
);

    logic [TIMER_W-1:0] count_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            count_q <= '0;
            expired <= 1'b1;
        end
        else if (start)
        begin
            count_q <= load;
            expired <= 1'b0;
        end
        else if (count_q != '0)
        begin
            count_q <= count_q - TIMER_W'(1);
            expired <= (count_q == TIMER_W'(1));
        end
    end

endmodule : fcs_timer

// File: rtl/fcs_sequencer.sv
`timescale 1ns/100ps
// What this block does
// - unlock addresses compare only the low 12 address bits
// - sequences act only while the command enable field is 0011
// - command enable field resets to 1100, sequences disabled
// - byte program: three unlock writes then address and data
// - sector erase: six writes, top address nibble picks the sector
// - serial bank 0 window F000-FFFF erases 7000-7FFF
// - sector erase refused in parallel programmer mode
// - chip erase: five shared writes then 10 at 555, all bytes FF
// - unlock plus 90 at 555 enters identification mode
// - id mode returns vendor, macro and size codes at F000-F002
// - id mode read of FF7F shows FF when unprotected
// - id mode left by single F0 write or unlock plus F0
// - read protect: unlock plus A5, then 00 written to FF7F
// - protection blocks parallel reads; in serial mode it only sets serial_cmds_blocked
// - only chip erase clears protection; serial read protect needs bank 1
// - busy reads return bit 6 inverted on each successive read
// - first poll after program, erase or protect returns bit 6 one
// - byte program finishes within 40 us
// - sector erase takes 30 ms plus one clock cycle
// - chip erase takes about 30 ms
// - read protect finishes within 40 us
module fcs_sequencer
    import fcs_pkg::*;
#(
    parameter int unsigned SECTOR_ERASE_CYCLES = SECTOR_ERASE_CYC,
    parameter int unsigned CHIP_ERASE_CYCLES   = CHIP_ERASE_CYC,
    // arbitrary identification values
    parameter logic [7:0]  VENDOR_CODE         = 8'h5a,
    parameter logic [7:0]  MACRO_CODE          = 8'h3c
)
(
    // clock and reset
    input wire logic                  clk,
    input wire logic                  rst_n,
    // operating mode
    input wire fcs_pkg::fcs_mode_type op_mode,
    // flash control register
    input wire logic                  ctl_wr,
    input wire logic [7:0]            ctl_wdata,
    output logic [7:0]                ctl_rdata,
    // cpu bus
    input wire logic                  bus_wr,
    input wire logic                  bus_rd,
    input wire logic [15:0]           bus_addr,
    input wire logic [7:0]            bus_wdata,
    output logic [7:0]                bus_rdata,
    output logic                      bus_rvalid,
    // status
    output logic                      busy,
    output logic                      id_mode,
    output logic                      read_protect,
    output logic                      serial_cmds_blocked
);

    import fcs_pkg::*;

    localparam logic [TIMER_W-1:0] PROG_LOAD    = TIMER_W'(PROG_CYC - 1); // busy flop adds one
    localparam logic [TIMER_W-1:0] PROTECT_LOAD = TIMER_W'(PROTECT_CYC - 1);
    localparam logic [TIMER_W-1:0] SECTOR_LOAD  = TIMER_W'(SECTOR_ERASE_CYCLES);
    localparam logic [TIMER_W-1:0] CHIP_LOAD    = TIMER_W'(CHIP_ERASE_CYCLES);

    function automatic logic [15:0] fcs_map(input logic [15:0] a,
                                            input fcs_mode_type m,
                                            input logic bank);
        if ((m == FCS_MODE_SERIAL) && !bank && a[15])
        begin
            return a - BANK0_OFFSET;
        end
        return a;
    endfunction : fcs_map

    function automatic logic [15:0] fcs_index(input logic [15:0] phys);
        return phys - ARRAY_BASE;
    endfunction : fcs_index

    function automatic logic [TIMER_W-1:0] fcs_op_load(input fcs_op_type op);
        case (op)
            FCS_OP_PROGRAM: return PROG_LOAD;
            FCS_OP_SECTOR:  return SECTOR_LOAD;
            FCS_OP_CHIP:    return CHIP_LOAD;
            default:        return PROTECT_LOAD;
        endcase
    endfunction : fcs_op_load

    fcs_arr_if arr ();

    fcs_state_type state_q;
    fcs_state_type state_d;
    fcs_op_type    op_q;
    fcs_op_type    launch_op;
    logic          launch;
    logic          id_enter;
    logic          id_exit;
    logic          cmd_ok;
    logic          bank_sel;
    logic [7:0]    ctl_q;
    logic [15:0]   wr_phys;
    logic [11:0]   a12;
    logic          timer_expired;
    logic [15:0]   sweep_q;
    logic [15:0]   sweep_end_q;
    logic          sweeping_q;
    logic          we_q;
    logic [15:0]   waddr_q;
    logic [7:0]    wdata_q;
    logic          rd_pend_q;
    logic [15:0]   rd_addr_q;
    logic [15:0]   rd_phys_q;
    logic          toggle_q;
    logic          first_q;
    logic          toggle_next;
    logic [7:0]    rd_value;

    assign bank_sel = ctl_q[BANK_SEL_BIT];
    assign wr_phys  = fcs_map(bus_addr, op_mode, bank_sel);
    assign a12      = bus_addr[11:0];

    // command decoder
    always_comb
    begin
        state_d   = state_q;
        launch    = 1'b0;
        launch_op = FCS_OP_PROGRAM;
        id_enter  = 1'b0;
        id_exit   = 1'b0;
        // writes during an operation are ignored
        cmd_ok    = bus_wr && (ctl_q[7:CMD_EN_LSB] == CMD_ENABLE)
                    && (state_q != FCS_ST_BUSY);
        if (cmd_ok)
        begin
            state_d = FCS_ST_IDLE;
            case (state_q)
                FCS_ST_IDLE:
                begin
                    if (bus_wdata == CODE_ID_EXIT)
                    begin
                        id_exit = 1'b1;
                    end
                    else if ((a12 == UNLOCK_ADDR_A) && (bus_wdata == CODE_UNLOCK_A))
                    begin
                        state_d = FCS_ST_U1;
                    end
                end
                FCS_ST_U1:
                begin
                    if ((a12 == UNLOCK_ADDR_B) && (bus_wdata == CODE_UNLOCK_B))
                    begin
                        state_d = FCS_ST_U2;
                    end
                end
                FCS_ST_U2:
                begin
                    if (a12 == UNLOCK_ADDR_A)
                    begin
                        case (bus_wdata)
                            CODE_PROGRAM:  state_d  = FCS_ST_PROG;
                            CODE_ERASE:    state_d  = FCS_ST_E3;
                            CODE_ID_ENTER: id_enter = 1'b1;
                            CODE_ID_EXIT:  id_exit  = 1'b1;
                            CODE_PROTECT:
                            begin
                                // serial mode must have bank 1 selected
                                if (!((op_mode == FCS_MODE_SERIAL) && !bank_sel))
                                begin
                                    state_d = FCS_ST_RP;
                                end
                            end
                            default:       state_d  = FCS_ST_IDLE;
                        endcase
                    end
                end
                FCS_ST_PROG:
                begin
                    if (wr_phys >= ARRAY_BASE)
                    begin
                        launch    = 1'b1;
                        launch_op = FCS_OP_PROGRAM;
                    end
                end
                FCS_ST_E3:
                begin
                    if ((a12 == UNLOCK_ADDR_A) && (bus_wdata == CODE_UNLOCK_A))
                    begin
                        state_d = FCS_ST_E4;
                    end
                end
                FCS_ST_E4:
                begin
                    if ((a12 == UNLOCK_ADDR_B) && (bus_wdata == CODE_UNLOCK_B))
                    begin
                        state_d = FCS_ST_E5;
                    end
                end
                FCS_ST_E5:
                begin
                    if ((a12 == UNLOCK_ADDR_A) && (bus_wdata == CODE_CHIP))
                    begin
                        launch    = 1'b1;
                        launch_op = FCS_OP_CHIP;
                    end
                    else if ((bus_wdata == CODE_SECTOR) && (op_mode != FCS_MODE_PARALLEL)
                             && (wr_phys[15:12] != 4'h0))
                    begin
                        launch    = 1'b1;
                        launch_op = FCS_OP_SECTOR;
                    end
                end
                FCS_ST_RP:
                begin
                    if ((bus_addr == PROTECT_ADDR) && (bus_wdata == CODE_PROTECT_CFM))
                    begin
                        launch    = 1'b1;
                        launch_op = FCS_OP_PROTECT;
                    end
                end
                default: state_d = FCS_ST_IDLE;
            endcase
            if (launch)
            begin
                state_d = FCS_ST_BUSY;
            end
        end
        else if (bus_wr && (state_q != FCS_ST_BUSY))
        begin
            state_d = FCS_ST_IDLE;
        end
        else if ((state_q == FCS_ST_BUSY) && timer_expired && !sweeping_q)
        begin
            state_d = FCS_ST_IDLE;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= FCS_ST_IDLE;
            op_q    <= FCS_OP_PROGRAM;
            busy    <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            busy    <= (state_d == FCS_ST_BUSY);
            if (launch)
            begin
                op_q <= launch_op;
            end
        end
    end

    // control register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctl_q     <= CTL_RESET;
            ctl_rdata <= CTL_RESET;
        end
        else if (ctl_wr)
        begin
            ctl_q     <= {ctl_wdata[7:3], 3'h0};
            ctl_rdata <= {ctl_wdata[7:3], 3'h0};
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            id_mode <= 1'b0;
        end
        else if (id_enter)
        begin
            id_mode <= 1'b1;
        end
        else if (id_exit)
        begin
            id_mode <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            read_protect        <= 1'b0;
            serial_cmds_blocked <= 1'b0;
        end
        else
        begin
            if (launch && (launch_op == FCS_OP_CHIP))
            begin
                read_protect <= 1'b0;
            end
            else if ((state_q == FCS_ST_BUSY) && (state_d == FCS_ST_IDLE)
                     && (op_q == FCS_OP_PROTECT))
            begin
                read_protect <= 1'b1;
            end
            serial_cmds_blocked <= read_protect && (op_mode == FCS_MODE_SERIAL);
        end
    end

    fcs_timer u_timer (
        .clk     (clk),
        .rst_n   (rst_n),
        .start   (launch),
        .load    (fcs_op_load(launch_op)),
        .expired (timer_expired)
    );

    // erase sweep writes one byte per cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sweep_q     <= '0;
            sweep_end_q <= '0;
            sweeping_q  <= 1'b0;
        end
        else if (launch && (launch_op == FCS_OP_CHIP))
        begin
            sweep_q     <= '0;
            sweep_end_q <= ARRAY_LAST_IDX;
            sweeping_q  <= 1'b1;
        end
        else if (launch && (launch_op == FCS_OP_SECTOR))
        begin
            sweep_q     <= fcs_index({wr_phys[15:12], 12'h000});
            sweep_end_q <= fcs_index({wr_phys[15:12], 12'h000}) + SECTOR_LAST_OFS;
            sweeping_q  <= 1'b1;
        end
        else if (sweeping_q)
        begin
            sweep_q    <= sweep_q + 16'h0001;
            sweeping_q <= (sweep_q != sweep_end_q);
        end
    end

    // array write port
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            we_q    <= 1'b0;
            waddr_q <= '0;
            wdata_q <= '0;
        end
        else if (launch && (launch_op == FCS_OP_PROGRAM))
        begin
            we_q    <= 1'b1;
            waddr_q <= fcs_index(wr_phys);
            wdata_q <= bus_wdata;
        end
        else
        begin
            we_q    <= sweeping_q;
            waddr_q <= sweep_q;
            wdata_q <= ERASED_BYTE;
        end
    end

    assign arr.we    = we_q;
    assign arr.waddr = waddr_q;
    assign arr.wdata = wdata_q;
    assign arr.raddr = fcs_index(fcs_map(bus_addr, op_mode, bank_sel));

    fcs_array u_array (
        .clk  (clk),
        .port (arr.mem)
    );

    // read pipeline: address cycle, array cycle, answer
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rd_pend_q <= 1'b0;
            rd_addr_q <= '0;
            rd_phys_q <= '0;
        end
        else
        begin
            rd_pend_q <= bus_rd;
            rd_addr_q <= bus_addr;
            rd_phys_q <= fcs_map(bus_addr, op_mode, bank_sel);
        end
    end

    assign toggle_next = first_q ? 1'b1 : ~toggle_q;

    always_comb
    begin
        rd_value = arr.rdata;
        if (state_q == FCS_ST_BUSY)
        begin
            rd_value                  = ERASED_BYTE;
            rd_value[BUSY_TOGGLE_BIT] = toggle_next;
        end
        else if ((op_mode == FCS_MODE_PARALLEL) && read_protect)
        begin
            rd_value = BLOCKED_READ_VAL;
        end
        else if (id_mode && (rd_addr_q == ID_VENDOR_ADDR))
        begin
            rd_value = VENDOR_CODE;
        end
        else if (id_mode && (rd_addr_q == ID_MACRO_ADDR))
        begin
            rd_value = MACRO_CODE;
        end
        else if (id_mode && (rd_addr_q == ID_SIZE_ADDR))
        begin
            rd_value = SIZE_CODE;
        end
        else if (id_mode && (rd_addr_q == PROTECT_ADDR))
        begin
            rd_value = read_protect ? PROTECT_ON_VAL : PROTECT_OFF_VAL;
        end
        else if (rd_phys_q < ARRAY_BASE)
        begin
            rd_value = UNMAPPED_VAL;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            toggle_q <= 1'b0;
            first_q  <= 1'b0;
        end
        else if (launch)
        begin
            first_q <= 1'b1;
        end
        else if (rd_pend_q && (state_q == FCS_ST_BUSY))
        begin
            toggle_q <= toggle_next;
            first_q  <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            bus_rdata  <= '0;
            bus_rvalid <= 1'b0;
        end
        else
        begin
            bus_rvalid <= rd_pend_q;
            if (rd_pend_q)
            begin
                bus_rdata <= rd_value;
            end
        end
    end

endmodule : fcs_sequencer

// File: dv/fcs_properties.sv
`timescale 1ns/100ps
module fcs_props
    import fcs_pkg::*;
(
    input wire logic         clk,
    input wire logic         rst_n,
    input wire fcs_mode_type op_mode,
    input wire logic         ctl_wr,
    input wire logic [7:0]   ctl_wdata,
    input wire logic [7:0]   ctl_rdata,
    input wire logic         bus_rd,
    input wire logic [7:0]   bus_rdata,
    input wire logic         bus_rvalid,
    input wire logic         busy,
    input wire logic         id_mode,
    input wire logic         read_protect,
    input wire logic         serial_cmds_blocked
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [16:0] busy_cnt_q;
    always_ff @(posedge clk)
    begin
        busy_cnt_q <= (busy && rst_n) ? busy_cnt_q + 17'h1 : 17'h0;
    end
    sequence s_answer;
        ##2 bus_rvalid;
    endsequence
    property p_reset_val;
        $rose(rst_n) |-> ctl_rdata == CTL_RESET && !busy && !id_mode && !read_protect;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("bad reset state");
    property p_ctl_wr;
        ctl_wr |=> ctl_rdata == ($past(ctl_wdata) & 8'hf8);
    endproperty
    a_ctl_wr: assert property (p_ctl_wr) else $error("control readback wrong");
    property p_disabled;
        ctl_rdata[7:4] != CMD_ENABLE && !busy |=> !busy;
    endproperty
    a_disabled: assert property (p_disabled) else $error("operation while disabled");
    property p_rd_answer;
        bus_rd |-> s_answer;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_busy_read;
        bus_rvalid && busy && $past(busy, 2) |-> (bus_rdata | 8'h40) == 8'hff;
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("busy read data wrong");
    property p_serial_block;
        serial_cmds_blocked == ($past(read_protect) && $past(op_mode) == FCS_MODE_SERIAL);
    endproperty
    a_serial_block: assert property (p_serial_block) else $error("block flag wrong");
    property p_protect_done;
        $rose(read_protect) |-> $fell(busy);
    endproperty
    a_protect_done: assert property (p_protect_done) else $error("protect early");
    property p_busy_bound;
        busy_cnt_q <= 17'hf005;
    endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
endmodule : fcs_props
bind fcs_sequencer fcs_props u_props (.clk(clk), .rst_n(rst_n), .op_mode(op_mode),
    .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .busy(busy), .id_mode(id_mode),
    .read_protect(read_protect), .serial_cmds_blocked(serial_cmds_blocked));

// File: dv/fcs_cpu.sv
`timescale 1ns/100ps
module fcs_cpu
(
    input wire logic   clk,
    input wire logic   bus_rvalid,
    input wire logic [7:0] bus_rdata,
    output logic       bus_wr,
    output logic       bus_rd,
    output logic [15:0] bus_addr,
    output logic [7:0] bus_wdata
);
    initial
    begin
        {bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
    end
    // lines change after the strobe so stale values never look valid
    task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        #1;
        {bus_wr, bus_rd, bus_addr, bus_wdata} = {w, !w, a, v};
        @(posedge clk);
        #1;
        {bus_wr, bus_rd, bus_addr, bus_wdata} = {2'h0, ~a, ~v};
    endtask : xfer
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        int i;
        xfer(1'b0, a, 8'h00);
        for (i = 0; i < 4; i++)
        begin
            @(posedge clk);
            #1;
            if (bus_rvalid === 1'b1) break;
        end
        if (i == 4) flash_command_sequencer_test.tmo();
        v = bus_rdata;
    endtask : rd
endmodule : fcs_cpu

// File: dv/flash_command_sequencer_test.sv
`timescale 1ns/100ps
module flash_command_sequencer_test;
    import fcs_pkg::*;
    logic         clk = 0, rst_n = 0, ctl_wr = 0;
    logic [7:0]   ctl_wdata = '0, ctl_rdata, bus_rdata, bus_wdata, d;
    logic         bus_wr, bus_rd, bus_rvalid, busy, id_mode, read_protect, scb;
    logic [15:0]  bus_addr;
    fcs_mode_type op_mode = FCS_MODE_MCU;
    int           n_fail = 0, check_count = 0;
    always #10 clk = ~clk;
    fcs_sequencer #(.SECTOR_ERASE_CYCLES(50), .CHIP_ERASE_CYCLES(50)) u_dut (.clk(clk),
        .rst_n(rst_n), .op_mode(op_mode), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
        .ctl_rdata(ctl_rdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .busy(busy),
        .id_mode(id_mode), .read_protect(read_protect), .serial_cmds_blocked(scb));
    fcs_cpu u_cpu (.clk(clk), .bus_rvalid(bus_rvalid), .bus_rdata(bus_rdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata));
    task automatic stop_test;
        if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task automatic tmo;
        n_fail++;
        stop_test();
    endtask : tmo
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic w(input logic [15:0] a, input logic [7:0] v);
        u_cpu.xfer(1'b1, a, v);
    endtask : w
    task automatic r(input logic [15:0] a, input logic [7:0] e);
        u_cpu.rd(a, d);
        chk(d, e);
    endtask : r
    task automatic cw(input logic [7:0] v);
        @(posedge clk);
        #1;
        {ctl_wr, ctl_wdata} = {1'b1, v};
        @(posedge clk);
        #1;
        ctl_wr = 0;
    endtask : cw
    task automatic unl(input logic [7:0] c);
        w(16'h0555, 8'haa);
        w(16'h0aaa, 8'h55);
        w(16'h0555, c);
    endtask : unl
    task automatic ers(input logic [15:0] a, input logic [7:0] c);
        unl(CODE_ERASE);
        w(16'h0555, 8'haa);
        w(16'h0aaa, 8'h55);
        w(a, c);
    endtask : ers
    // wait for busy to drop within n cycles
    task automatic idle(input int n);
        int i;
        for (i = 0; i < n && busy !== 1'b0; i++)
        begin
            @(posedge clk);
            #1;
        end
        if (busy !== 1'b0) tmo();
    endtask : idle
    initial
    begin
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1;
        chk(ctl_rdata, 8'hc8);
        unl(CODE_PROGRAM);
        w(16'h7000, 8'h00);
        chk({7'h0, busy}, 8'h00);
        cw(8'h38);
        chk(ctl_rdata, 8'h38);
        ers(16'h7abc, CODE_SECTOR);
        r(16'h7000, 8'hff);
        r(16'h7000, 8'hbf);
        idle(4200);
        ers(16'hf000, CODE_SECTOR);
        idle(4200);
        r(16'h7fff, 8'hff);
        w(16'hf555, 8'haa);
        w(16'h3aaa, 8'h55);
        w(16'h7555, CODE_PROGRAM);
        w(16'h7000, 8'h3c);
        idle(2000);
        r(16'h7000, 8'h3c);
        unl(CODE_PROGRAM);
        w(16'hf000, 8'h3f);
        idle(2000);
        w(16'h0555, 8'haa);
        w(16'h0aaa, 8'h00);
        w(16'h0555, CODE_PROGRAM);
        w(16'hf010, 8'h11);
        chk({7'h0, busy}, 8'h00);
        r(16'hf010, 8'hff);
        op_mode = FCS_MODE_PARALLEL;
        ers(16'hf000, CODE_SECTOR);
        chk({7'h0, busy}, 8'h00);
        op_mode = FCS_MODE_SERIAL;
        cw(8'h30);
        ers(16'hf123, CODE_SECTOR);
        idle(4200);
        op_mode = FCS_MODE_MCU;
        r(16'h7000, 8'hff);
        r(16'hf000, 8'h3f);
        unl(CODE_ID_ENTER);
        chk({7'h0, id_mode}, 8'h01);
        r(16'hf000, 8'h5a);
        r(16'hf001, 8'h3c);
        r(16'hf002, 8'h0e);
        r(16'hff7f, 8'hff);
        w(16'h0123, CODE_ID_EXIT);
        chk({7'h0, id_mode}, 8'h00);
        unl(CODE_ID_ENTER);
        chk({7'h0, id_mode}, 8'h01);
        unl(CODE_ID_EXIT);
        chk({7'h0, id_mode}, 8'h00);
        unl(CODE_PROTECT);
        w(16'hff7f, 8'h00);
        r(16'h1000, 8'hff);
        idle(2000);
        chk({7'h0, read_protect}, 8'h01);
        unl(CODE_ID_ENTER);
        r(16'hff7f, 8'h00);
        w(16'h0000, CODE_ID_EXIT);
        op_mode = FCS_MODE_PARALLEL;
        r(16'hf000, 8'hff);
        op_mode = FCS_MODE_SERIAL;
        @(posedge clk);
        #1;
        chk({7'h0, scb}, 8'h01);
        op_mode = FCS_MODE_MCU;
        ers(16'h0555, CODE_CHIP);
        idle(62000);
        chk({7'h0, read_protect}, 8'h00);
        r(16'hf000, 8'hff);
        op_mode = FCS_MODE_SERIAL;
        unl(CODE_PROTECT);
        w(16'hff7f, 8'h00);
        chk({7'h0, busy}, 8'h00);
        stop_test();
    end
endmodule : flash_command_sequencer_test
